/* File: inc/stl_pkg.sv */
/*
 Shared constants and carriers for the safe torque limit monitor.
 Assumes one 25 MHz control clock and word-aligned AHB-Lite access.
*/
package stl_pkg;
	localparam int TQ_W = 16;

	// Safety commands, 1 = on (function not requested), 0 = off (requested)
	typedef struct packed {
		logic [3:0] limit;
		logic       stop;
		logic       off;
	} stl_cmd_t;

	// Alarm stop methods as reported with an alarm
	typedef enum logic [2:0] {
		MTH_DYNAMIC_BRAKING,
		MTH_ELECTRONIC_BRAKING,
		MTH_FORCED_DECEL,
		MTH_OFF_DYNAMIC,
		MTH_STOP_ELECTRONIC,
		MTH_STOP_FORCED
	} stl_method_t;

	typedef enum logic [1:0] {CS_IDLE, CS_DECEL, CS_OFF} stl_cs_t;

	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_NETCMD   = 8'h04;
	localparam logic [7:0] REG_DELAY    = 8'h08;
	localparam logic [7:0] REG_STOPTIME = 8'h0C;
	localparam logic [7:0] REG_UPPER    = 8'h10;
	localparam logic [7:0] REG_LOWER    = 8'h20;
	localparam logic [7:0] REG_STATUS   = 8'h30;
	localparam logic [7:0] REG_ALARM    = 8'h34;

	localparam int CTRL_NET_BIT = 0;
	localparam int CTRL_ASSIGN_LSB = 8;

	localparam logic [5:0]      RST_ASSIGN   = 6'h3F;
	localparam logic [5:0]      RST_NETCMD   = 6'h3F;
	localparam logic [15:0]     RST_DELAY    = 16'h0010;
	localparam logic [23:0]     RST_STOPTIME = 24'h000400;
	localparam logic [TQ_W-1:0] RST_UPPER    = 16'h7FFF;
	localparam logic [TQ_W-1:0] RST_LOWER    = 16'h8000;

	// Status bit positions
	localparam int ST_STANDSTILL = 0;
	localparam int ST_BRAKE      = 1;
	localparam int ST_DIRECTION  = 2;
	localparam int ST_INCREMENT  = 3;
	localparam int ST_TORQUE_LIM = 4;
	localparam int ST_TORQUE_OFF = 5;
	localparam int ST_CTRL_STOP  = 6;
	localparam int ST_SPEED_LIM  = 7;
endpackage

/* File: tb/stl_ctrl_model.sv */
/*
 Pin-mode safety controller model that drives the monitor's command pins.
 Assumes the bench gives the wanted command levels and a reset request level.
*/
`timescale 1ns/1ns
`default_nettype none
module stl_ctrl_model (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire stl_pkg::stl_cmd_t cmdReq,
	input  wire logic [5:0]        spareMask,
	input  wire logic              resetReq,
	output var  stl_pkg::stl_cmd_t cmdPin,
	output var  logic              alarmReset
);
	import stl_pkg::*;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmdPin <= 6'h3F;
			alarmReset <= 1'b0;
		end else begin
			// Spare pins keep their level, so the device must ignore them
			cmdPin <= resetReq ? (cmdReq | ~spareMask) : cmdReq;
			// Reset only once every enabled pin already reads on
			alarmReset <= resetReq & (&(cmdPin | spareMask));
		end
	end
endmodule
`default_nettype wire

/* File: tb/stl_torque_monitor_tb.sv */
/*
 Self-checking bench for the safe torque limit monitor.
 Assumes zero-wait AHB-Lite access and the pin-mode controller model.
*/
`timescale 1ns/1ns
`default_nettype none
module stl_torque_monitor_tb;
	import stl_pkg::*;

	logic               clock        = 1'b0;
	logic               rst          = 1'b1;
	stl_cmd_t           cmdReq       = 6'h3F;
	stl_cmd_t           cmdPin;
	logic [5:0]         spareMask    = 6'h00;
	logic               resetReq     = 1'b0;
	logic               alarmReset;
	logic signed [15:0] tqCmd        = 16'sh0000;
	logic signed [15:0] tqFb         = 16'sh0000;
	logic               faultAlarm   = 1'b0;
	stl_method_t        faultMethod  = MTH_DYNAMIC_BRAKING;
	logic               seriousError = 1'b0;
	logic               commReset    = 1'b0;
	logic [4:0]         otherStatus  = 5'h15;
	logic               torqueEnable;
	logic               decelRequest;
	logic [7:0]         safetyStatus;
	logic               hsel         = 1'b0;
	logic [31:0]        haddr        = 32'h0;
	logic [1:0]         htrans       = 2'h0;
	logic               hwrite       = 1'b0;
	logic [2:0]         hsize        = 3'h2;
	logic [31:0]        hwdata       = 32'h0;
	logic [31:0]        hrdata;
	logic               hreadyout;
	logic               hresp;
	logic [31:0]        rdata;
	int                 n_errors     = 0;
	int                 compares     = 0;
	int                 cycles       = 0;

	stl_ctrl_model i_ctrl (.clock(clock), .rst(rst), .cmdReq(cmdReq), .spareMask(spareMask),
		.resetReq(resetReq), .cmdPin(cmdPin), .alarmReset(alarmReset));

	stl_torque_monitor i_dut (.clock(clock), .rst(rst), .cmdPin(cmdPin),
		.torqueCommand(tqCmd), .torqueFeedback(tqFb), .faultAlarm(faultAlarm),
		.faultMethod(faultMethod), .seriousError(seriousError), .alarmReset(alarmReset),
		.commReset(commReset), .otherStatus(otherStatus), .torqueEnable(torqueEnable),
		.decelRequest(decelRequest), .safetyStatus(safetyStatus), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

	always #20 clock = ~clock;

	task automatic conclude();
		if (n_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk("register", exp, rdata);
	endtask

	// Pin-mode alarm reset through the controller model
	task automatic clearAlarm();
		resetReq <= 1'b1;
		cyc(5);
		resetReq <= 1'b0;
		cyc(5);
	endtask

	initial begin
		cyc(4);
		rst <= 1'b0;
		cyc(3);
		chk("enable", 1, torqueEnable);
		chk("status", 8'h85, safetyStatus);
		rd(REG_DELAY, 32'h10);
		rd(REG_CTRL, 32'h3F00);
		rd(8'h40, 32'h0);
		bus(1'b1, REG_DELAY, 32'h3);
		bus(1'b1, REG_STOPTIME, 32'd20);
		bus(1'b1, REG_UPPER, 32'd100);
		bus(1'b1, REG_UPPER + 8'h04, 32'd50);
		rd(REG_UPPER + 8'h04, 32'd50);
		// Only limit 1 active: 75 is inside its range
		cmdReq.limit <= 4'hE;
		tqCmd <= 16'sd75;
		cyc(10);
		chk("enable", 1, torqueEnable);
		chk("limit active", 1, safetyStatus[ST_TORQUE_LIM]);
		cmdReq.limit <= 4'hC;
		cyc(10);
		chk("enable", 0, torqueEnable);
		tqCmd <= 16'sd0;
		clearAlarm();
		chk("enable", 1, torqueEnable);
		// A one-cycle command excursion still trips after the delay
		tqCmd <= 16'sd75;
		cyc(1);
		tqCmd <= 16'sd0;
		cyc(2);
		chk("enable", 1, torqueEnable);
		cyc(3);
		chk("enable", 0, torqueEnable);
		clearAlarm();
		tqFb <= 16'sd60;
		cyc(2);
		tqFb <= 16'sd0;
		cyc(8);
		chk("enable", 1, torqueEnable);
		tqFb <= 16'sd60;
		cyc(8);
		chk("enable", 0, torqueEnable);
		tqFb <= 16'sd0;
		cmdReq.limit <= 4'hF;
		clearAlarm();
		cyc(3);
		chk("limit active", 0, safetyStatus[ST_TORQUE_LIM]);
		// Torque off in mid-stop freezes the stop timer
		cmdReq.stop <= 1'b0;
		cyc(4);
		chk("decel", 1, decelRequest);
		cmdReq.off <= 1'b0;
		cyc(4);
		chk("decel", 0, decelRequest);
		chk("enable", 0, torqueEnable);
		cyc(30);
		cmdReq.off <= 1'b1;
		cyc(4);
		chk("decel", 1, decelRequest);
		cyc(30);
		chk("enable", 0, torqueEnable);
		cmdReq.stop <= 1'b1;
		clearAlarm();
		cmdReq.off <= 1'b0;
		cyc(4);
		cmdReq.stop <= 1'b0;
		cyc(10);
		chk("decel", 0, decelRequest);
		cmdReq.off <= 1'b1;
		cyc(10);
		chk("enable", 0, torqueEnable);
		chk("decel", 0, decelRequest);
		cmdReq.stop <= 1'b1;
		clearAlarm();
		chk("enable", 1, torqueEnable);
		// Alarm joins a running stop; command release must not end it
		cmdReq.stop <= 1'b0;
		cyc(10);
		faultMethod <= MTH_STOP_ELECTRONIC;
		faultAlarm <= 1'b1;
		cyc(1);
		faultAlarm <= 1'b0;
		cmdReq.stop <= 1'b1;
		cyc(4);
		chk("decel", 1, decelRequest);
		cyc(12);
		chk("enable", 0, torqueEnable);
		clearAlarm();
		for (int m = 0; m < 6; m++) begin
			faultMethod <= stl_method_t'(m);
			faultAlarm <= 1'b1;
			cyc(1);
			faultAlarm <= 1'b0;
			cyc(30);
			chk("alarm stop", (m < 3), torqueEnable);
			commReset <= 1'b1;
			cyc(2);
			commReset <= 1'b0;
			cyc(3);
			chk("alarm clear", 1, torqueEnable);
		end
		// Limit 4 pin unassigned and left off through the reset
		bus(1'b1, REG_CTRL, 32'h1F00);
		spareMask <= 6'h20;
		cmdReq.limit <= 4'h7;
		faultMethod <= MTH_OFF_DYNAMIC;
		faultAlarm <= 1'b1;
		cyc(1);
		faultAlarm <= 1'b0;
		cyc(4);
		chk("limit active", 0, safetyStatus[ST_TORQUE_LIM]);
		clearAlarm();
		chk("enable", 1, torqueEnable);
		// Network control: reset is refused until the off command is back on
		bus(1'b1, REG_CTRL, 32'h00003F01);
		bus(1'b1, REG_NETCMD, 32'h0000003E);
		faultAlarm <= 1'b1;
		cyc(1);
		faultAlarm <= 1'b0;
		commReset <= 1'b1;
		cyc(2);
		commReset <= 1'b0;
		cyc(3);
		chk("enable", 0, torqueEnable);
		rd(REG_ALARM, 32'h00000031);
		rd(REG_STATUS, 32'h000000A5);
		chk("hresp", 0, hresp);
		bus(1'b1, REG_NETCMD, 32'h0000003F);
		cyc(3);
		chk("enable", 0, torqueEnable);
		commReset <= 1'b1;
		cyc(2);
		commReset <= 1'b0;
		cyc(3);
		chk("enable", 1, torqueEnable);
		seriousError <= 1'b1;
		cyc(1);
		seriousError <= 1'b0;
		cyc(3);
		clearAlarm();
		chk("enable", 0, torqueEnable);
		chk("status", 8'h00, safetyStatus);
		chk("decel", 0, decelRequest);
		conclude();
	end
endmodule
`default_nettype wire

/* File: verilog/stl_delay_trip.sv */
/*
 Detection delay timer for one monitored torque quantity.
 Assumes monitor and outside are synchronous levels from the parent.
*/
`timescale 1ns/1ns
`default_nettype none
module stl_delay_trip #(
	parameter int DLY_W = 16,
	parameter bit LATCH = 1'b0
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             monitor,
	input  wire logic             outside,
	input  wire logic [DLY_W-1:0] delay,
	output var  logic             trip
);
	typedef struct packed {
		logic             pend;
		logic [DLY_W-1:0] cnt;
		logic             trip;
	} stl_dt_state_t;

	stl_dt_state_t st_reg;
	stl_dt_state_t st_next;
	logic          hit;

	if (DLY_W < 1 || DLY_W > 32) begin : g_chk
		$error("stl_delay_trip: DLY_W out of range");
	end

	always_comb begin
		st_next = st_reg;
		// Latched mode keeps counting once seen; plain mode needs it held
		hit = outside | (LATCH & st_reg.pend);
		if (!monitor || !hit) begin
			st_next.pend = 1'b0;
			st_next.cnt  = '0;
			st_next.trip = 1'b0;
		end else begin
			st_next.pend = 1'b1;
			if (st_reg.cnt >= delay) begin
				st_next.trip = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign trip = st_reg.trip;

	property p_clear_idle;
		@(posedge clock) disable iff (rst)
		!monitor |=> (st_reg.cnt == '0) && !trip;
	endproperty
	a_clear_idle: assert property (p_clear_idle) else $error("timer not cleared");

	property p_held_fault;
		@(posedge clock) disable iff (rst)
		(!LATCH && $rose(trip)) |-> $past(outside) && $past(monitor);
	endproperty
	a_held_fault: assert property (p_held_fault) else $error("trip without fault");
endmodule
`default_nettype wire

/* File: verilog/stl_torque_monitor.sv */
/*
 Safe torque limit monitor with torque-off and controlled-stop arbitration,
 alarm stop latch, status outputs and AHB-Lite register slave.
 Assumes all inputs are synchronous to clock and a single AHB-Lite master.
*/
`timescale 1ns/1ns
`default_nettype none
module stl_torque_monitor #(
	parameter int DLY_W  = 16,
	parameter int STOP_W = 24
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire stl_pkg::stl_cmd_t        cmdPin,
	input  wire logic signed [15:0]       torqueCommand,
	input  wire logic signed [15:0]       torqueFeedback,
	input  wire logic                     faultAlarm,
	input  wire stl_pkg::stl_method_t     faultMethod,
	input  wire logic                     seriousError,
	input  wire logic                     alarmReset,
	input  wire logic                     commReset,
	input  wire logic [4:0]               otherStatus,
	output var  logic                     torqueEnable,
	output var  logic                     decelRequest,
	output var  logic [7:0]               safetyStatus,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output var  logic [31:0]              hrdata,
	output var  logic                     hreadyout,
	output var  logic                     hresp
);
	import stl_pkg::*;

	typedef struct packed {
		logic                      netMode;
		logic [5:0]                assign6;
		stl_cmd_t                  netCmd;
		logic [DLY_W-1:0]          delay;
		logic [STOP_W-1:0]         stopTime;
		logic [3:0][TQ_W-1:0]      upper;
		logic [3:0][TQ_W-1:0]      lower;
		logic                      alarmOn;
		stl_method_t               method;
		logic                      offLatch;
		logic                      halted;
		stl_cs_t                   cs;
		logic [STOP_W-1:0]         stopCnt;
		logic                      torqueEnable;
		logic                      decelRequest;
		logic [7:0]                status;
		logic                      dAct;
		logic [7:0]                dAddr;
		logic [31:0]               hrdata;
		logic                      hreadyout;
	} stl_state_t;

	stl_state_t            st_reg;
	stl_state_t            st_next;
	stl_cmd_t              act;
	logic                  sltOn;
	logic signed [TQ_W-1:0] upSel;
	logic signed [TQ_W-1:0] lowSel;
	logic [1:0]            outside;
	logic [1:0]            tripVec;
	logic                  trip;
	logic                  stoReq;
	logic                  ss1Req;
	logic                  releaseOk;
	logic                  clearAlarm;
	logic                  addrPhase;

	if (DLY_W < 1 || DLY_W > 32 || STOP_W < 1 || STOP_W > 32) begin : g_chk
		$error("stl_torque_monitor: width parameter out of range");
	end

	// Register index within a bank of four, or 4 when the address misses it
	function automatic logic [2:0] bankIdx(input logic [7:0] a, input logic [7:0] base);
		bankIdx = (a[7:4] == base[7:4]) ? {1'b0, a[3:2]} : 3'h4;
	endfunction

	function automatic logic [31:0] readMux(input stl_state_t s, input logic [7:0] a);
		logic [2:0] ui;
		logic [2:0] li;
		ui = bankIdx(a, REG_UPPER);
		li = bankIdx(a, REG_LOWER);
		readMux = '0;
		if (a == REG_CTRL) begin
			readMux[CTRL_NET_BIT] = s.netMode;
			readMux[CTRL_ASSIGN_LSB +: 6] = s.assign6;
		end else if (a == REG_NETCMD) begin
			readMux[5:0] = s.netCmd;
		end else if (a == REG_DELAY) begin
			readMux[DLY_W-1:0] = s.delay;
		end else if (a == REG_STOPTIME) begin
			readMux[STOP_W-1:0] = s.stopTime;
		end else if (ui != 3'h4) begin
			readMux[TQ_W-1:0] = s.upper[ui[1:0]];
		end else if (li != 3'h4) begin
			readMux[TQ_W-1:0] = s.lower[li[1:0]];
		end else if (a == REG_STATUS) begin
			readMux[7:0] = s.status;
			readMux[9:8] = s.cs;
			readMux[10] = s.halted;
			readMux[11] = s.offLatch;
		end else if (a == REG_ALARM) begin
			readMux[0] = s.alarmOn;
			readMux[6:4] = s.method;
		end
	endfunction

	// Unassigned pins count as on so they never request nor block release
	always_comb begin
		if (st_reg.netMode) begin
			act = ~st_reg.netCmd;
		end else begin
			act = st_reg.assign6 & ~cmdPin;
		end
	end

	always_comb begin
		sltOn  = |act.limit;
		upSel  = $signed(RST_UPPER);
		lowSel = $signed(RST_LOWER);
		for (int i = 0; i < 4; i++) begin
			if (act.limit[i]) begin
				if ($signed(st_reg.upper[i]) < upSel) begin
					upSel = $signed(st_reg.upper[i]);
				end
				if ($signed(st_reg.lower[i]) > lowSel) begin
					lowSel = $signed(st_reg.lower[i]);
				end
			end
		end
		outside[0] = (torqueCommand > upSel) || (torqueCommand < lowSel);
		outside[1] = (torqueFeedback > upSel) || (torqueFeedback < lowSel);
	end

	// Instance 0 watches the command and latches, 1 watches feedback
	for (genvar g = 0; g < 2; g++) begin : g_tmr
		stl_delay_trip #(.DLY_W(DLY_W), .LATCH(g == 0)) u_dt (
			.clock  (clock),
			.rst    (rst),
			.monitor(sltOn),
			.outside(outside[g]),
			.delay  (st_reg.delay),
			.trip   (tripVec[g])
		);
	end
	assign trip = |tripVec;

	always_comb begin
		st_next = st_reg;
		// Sources are ORed so any one keeps the function active
		// A fresh trip cuts torque at once; the latch only keeps it cut
		stoReq = act.off | st_reg.offLatch | trip
			| (st_reg.alarmOn & (st_reg.method == MTH_OFF_DYNAMIC));
		ss1Req = act.stop | (st_reg.alarmOn & ((st_reg.method == MTH_STOP_ELECTRONIC)
			| (st_reg.method == MTH_STOP_FORCED)));
		releaseOk = st_reg.netMode ? st_reg.netCmd.off : (act == '0);
		clearAlarm = (alarmReset | commReset) & ~faultAlarm & ~trip & releaseOk;

		// Alarm capture beats reset: an alarm present blocks the clear
		if (clearAlarm) begin
			st_next.alarmOn  = 1'b0;
			st_next.offLatch = 1'b0;
		end
		if (faultAlarm && !st_reg.alarmOn) begin
			st_next.alarmOn = 1'b1;
			st_next.method  = faultMethod;
		end
		if (trip) begin
			st_next.offLatch = 1'b1;
		end
		if (seriousError) begin
			st_next.halted = 1'b1;
		end

		case (st_reg.cs)
			CS_IDLE: begin
				if (ss1Req) begin
					st_next.stopCnt = '0;
					// Already without torque: skip deceleration entirely
					if (stoReq || !st_reg.torqueEnable) begin
						st_next.cs = CS_OFF;
					end else begin
						st_next.cs = CS_DECEL;
					end
				end
			end
			CS_DECEL: begin
				if (!ss1Req) begin
					st_next.cs = CS_IDLE;
				end else if (stoReq) begin
					st_next.stopCnt = st_reg.stopCnt;
				end else if (st_reg.stopCnt >= st_reg.stopTime) begin
					st_next.cs = CS_OFF;
				end else begin
					st_next.stopCnt = st_reg.stopCnt + 1'b1;
				end
			end
			CS_OFF: begin
				if (!ss1Req) begin
					st_next.cs = CS_IDLE;
				end
			end
			default: begin
				st_next.cs = CS_IDLE;
			end
		endcase

		if (st_next.halted) begin
			st_next.torqueEnable = 1'b0;
			st_next.decelRequest = 1'b0;
			st_next.status       = '0;
		end else begin
			st_next.torqueEnable = ~(stoReq | (st_next.cs == CS_OFF));
			st_next.decelRequest = (st_next.cs == CS_DECEL) & ~stoReq;
			st_next.status[ST_STANDSTILL] = otherStatus[0];
			st_next.status[ST_BRAKE]      = otherStatus[1];
			st_next.status[ST_DIRECTION]  = otherStatus[2];
			st_next.status[ST_INCREMENT]  = otherStatus[3];
			st_next.status[ST_TORQUE_LIM] = sltOn;
			st_next.status[ST_TORQUE_OFF] = ~st_next.torqueEnable;
			st_next.status[ST_CTRL_STOP]  = st_next.cs != CS_IDLE;
			st_next.status[ST_SPEED_LIM]  = otherStatus[4];
		end

		// Bus: zero wait states; write lands in the data phase
		if (st_reg.dAct) begin
			if (st_reg.dAddr == REG_CTRL) begin
				st_next.netMode = hwdata[CTRL_NET_BIT];
				st_next.assign6 = hwdata[CTRL_ASSIGN_LSB +: 6];
			end else if (st_reg.dAddr == REG_NETCMD) begin
				st_next.netCmd = hwdata[5:0];
			end else if (st_reg.dAddr == REG_DELAY) begin
				st_next.delay = hwdata[DLY_W-1:0];
			end else if (st_reg.dAddr == REG_STOPTIME) begin
				st_next.stopTime = hwdata[STOP_W-1:0];
			end else if (bankIdx(st_reg.dAddr, REG_UPPER) != 3'h4) begin
				st_next.upper[st_reg.dAddr[3:2]] = hwdata[TQ_W-1:0];
			end else if (bankIdx(st_reg.dAddr, REG_LOWER) != 3'h4) begin
				st_next.lower[st_reg.dAddr[3:2]] = hwdata[TQ_W-1:0];
			end
		end
		addrPhase = hsel & htrans[1] & hready;
		st_next.dAct  = addrPhase & hwrite & (hsize == 3'b010);
		st_next.dAddr = haddr[7:0];
		st_next.hreadyout = 1'b1;
		if (addrPhase && !hwrite) begin
			st_next.hrdata = readMux(st_reg, haddr[7:0]);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg           <= '0;
			st_reg.assign6   <= RST_ASSIGN;
			st_reg.netCmd    <= RST_NETCMD;
			st_reg.delay     <= DLY_W'(RST_DELAY);
			st_reg.stopTime  <= STOP_W'(RST_STOPTIME);
			st_reg.upper     <= {4{RST_UPPER}};
			st_reg.lower     <= {4{RST_LOWER}};
			st_reg.method    <= MTH_DYNAMIC_BRAKING;
			st_reg.cs        <= CS_IDLE;
			st_reg.hreadyout <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign torqueEnable = st_reg.torqueEnable;
	assign decelRequest = st_reg.decelRequest;
	assign safetyStatus = st_reg.status;
	assign hrdata       = st_reg.hrdata;
	assign hreadyout    = st_reg.hreadyout;
	assign hresp        = 1'b0;

	property p_halt;
		@(posedge clock) disable iff (rst)
		seriousError |=> !torqueEnable && (safetyStatus == 8'h00) && !decelRequest;
	endproperty
	a_halt: assert property (p_halt) else $error("halt left outputs on");

	property p_trip_off;
		@(posedge clock) disable iff (rst)
		trip |=> !torqueEnable ##1 !torqueEnable;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip did not cut torque");

	property p_cmd_off;
		@(posedge clock) disable iff (rst)
		act.off |=> !torqueEnable;
	endproperty
	a_cmd_off: assert property (p_cmd_off) else $error("off command ignored");

	property p_suspend;
		@(posedge clock) disable iff (rst)
		(st_reg.cs == CS_DECEL) && stoReq && ss1Req |=> $stable(st_reg.stopCnt) && !decelRequest;
	endproperty
	a_suspend: assert property (p_suspend) else $error("stop timer ran during off");

	property p_no_decel;
		@(posedge clock) disable iff (rst)
		(st_reg.cs == CS_IDLE) && ss1Req && !torqueEnable |=> st_reg.cs == CS_OFF;
	endproperty
	a_no_decel: assert property (p_no_decel) else $error("decel entered while off");

	property p_hold_off;
		@(posedge clock) disable iff (rst)
		(st_reg.cs == CS_OFF) && ss1Req |=> !torqueEnable;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("torque released during stop");

	property p_alarm_latch;
		@(posedge clock) disable iff (rst)
		st_reg.alarmOn && (st_reg.method == MTH_OFF_DYNAMIC) && !alarmReset && !commReset
			|=> !torqueEnable && st_reg.alarmOn;
	endproperty
	a_alarm_latch: assert property (p_alarm_latch) else $error("alarm off not latched");

	property p_mon_status;
		@(posedge clock) disable iff (rst)
		sltOn && !st_reg.halted && !seriousError |=> safetyStatus[ST_TORQUE_LIM];
	endproperty
	a_mon_status: assert property (p_mon_status) else $error("limit status missing");
endmodule
`default_nettype wire
